// ===== hw/lsi_pkg.sv
// shared constants, register map and carrier types for the light sensor i2c target
package lsi_pkg;

  // register pointer values
  localparam logic [7:0] REG_CH0_RESULT_HIGH = 8'h00;
  localparam logic [7:0] REG_CH0_RESULT_LOW = 8'h01;
  localparam logic [7:0] REG_CH1_RESULT_HIGH = 8'h02;
  localparam logic [7:0] REG_CH1_RESULT_LOW = 8'h03;
  localparam logic [7:0] REG_CH0_QUEUED_HIGH = 8'h04;
  localparam logic [7:0] REG_CH0_QUEUED_LOW = 8'h05;
  localparam logic [7:0] REG_CH1_QUEUED_HIGH = 8'h06;
  localparam logic [7:0] REG_CH1_QUEUED_LOW = 8'h07;
  localparam logic [7:0] REG_LOW_LIMIT = 8'h08;
  localparam logic [7:0] REG_HIGH_LIMIT = 8'h09;
  localparam logic [7:0] REG_CONVERSION_SETUP = 8'h0A;
  localparam logic [7:0] REG_INTERRUPT_AND_BUS_SETUP = 8'h0B;
  localparam logic [7:0] REG_EVENT_FLAGS = 8'h0C;
  localparam logic [7:0] REG_PART_IDENTITY = 8'h11;

  // reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] CONVERSION_SETUP_RESET = 16'h0000;
  localparam logic [15:0] BUS_SETUP_RESET = 16'h0000;

  // field positions
  localparam int BURST_ENABLE_BIT = 0;

  // bus codes
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h44;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [7:0] GENERAL_CALL_RESET = 8'h06;
  localparam logic [4:0] HIGH_SPEED_CODE_PREFIX = 5'h01;

  // timing
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BUS_TIMEOUT_MS = 28;
  localparam int unsigned TIMEOUT_CYCLES_DEF = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam logic [1:0] FILTER_FS_CYCLES = 2'h2;
  localparam logic [1:0] FILTER_HS_CYCLES = 2'h1;

  // sensor values presented to the register file
  typedef struct packed {
    logic [7:0][15:0] value;
    logic [15:0] flags;
  } lsi_results_type;

  // software-written setup registers
  typedef struct packed {
    logic [15:0] low_limit;
    logic [15:0] high_limit;
    logic [15:0] conversion_setup;
    logic [15:0] bus_setup;
  } lsi_setup_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK_PEND, ST_ACK, ST_TX, ST_TX_LAST, ST_MACK
  } lsi_state_type;

  typedef enum logic [2:0] {
    PH_ADDR, PH_PTR, PH_DATA_HI, PH_DATA_LO, PH_GC
  } lsi_phase_type;

endpackage

// ===== hw/lsi_sync.sv
// two-flop synchroniser with a selectable spike filter per bit
`timescale 1ns/1ps
module lsi_sync import lsi_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filter select: high in high speed mode
  input wire logic fast,
  // async pins in, filtered levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q, stab_q, out_q, out_d;
  logic [WIDTH-1:0][1:0] cnt_q, cnt_d;
  logic [1:0] len;

  // a level must hold len samples; hs timing leaves room for one only
  always_comb begin
    len = fast ? FILTER_HS_CYCLES : FILTER_FS_CYCLES;
    out_d = out_q;
    cnt_d = cnt_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (stab_q[i] == out_q[i]) begin
        cnt_d[i] = 2'h0;
      end else if (cnt_q[i] + 2'h1 >= len) begin
        out_d[i] = stab_q[i];
        cnt_d[i] = 2'h0;
      end else begin
        cnt_d[i] = cnt_q[i] + 2'h1;
      end
    end
  end

  // idle bus lines are high, so reset to ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      stab_q <= '1;
      out_q <= '1;
      cnt_q <= '0;
    end else begin
      meta_q <= din;
      stab_q <= meta_q;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign dout = out_q;

endmodule // lsi_sync

// ===== hw/lsi_i2c_target.sv
// i2c target register access for the dual channel light sensor
//
// Functional notes
// - first byte after a write address byte loads the register pointer
// - acknowledge an address byte matching the strapped target address
// - two bytes after the pointer form the register word, each acknowledged
// - reads return the register named by the last written pointer
// - read sends upper byte then lower byte, controller acknowledges each
// - pointer persists across transactions until a new write replaces it
// - high speed code is not acknowledged but switches the input filters
// - after code use normal protocol; any stop leaves high speed mode
// - with burst enabled the pointer advances after each two-byte read whose low byte the controller acknowledges
// - auto-increment only while the burst enable bit is set
// - a stop restores the pointer value held before auto-increments
// - general call then reset byte: acknowledge and reload power-on defaults
// - live and queued result registers sit at consecutive pointers
// - scl held low for the timeout period resets the bus state machine
// - address strap picks one of four addresses, sampled every transaction
// - bytes travel most significant bit first
`timescale 1ns/1ps
module lsi_i2c_target import lsi_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
  parameter logic [15:0] PART_ID_VALUE = 16'h5A01 // arbitrary value
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // i2c pins, sda is open drain
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // address strap: 0 gnd, 1 vdd, 2 sda, 3 scl
  input wire logic [1:0] ADDR_SEL,
  // sensor side
  input wire lsi_results_type RESULTS,
  output lsi_setup_type SETUP,
  output logic HIGH_SPEED_MODE
);

  // read mux over the whole map; unmapped pointers read zero
  function automatic logic [15:0] rd_word(input logic [7:0] ptr,
                                          input lsi_results_type res,
                                          input lsi_setup_type set,
                                          input logic [15:0] part);
    logic [15:0] w;
    w = 16'h0000;
    case (ptr)
      REG_CH0_RESULT_HIGH, REG_CH0_RESULT_LOW, REG_CH1_RESULT_HIGH, REG_CH1_RESULT_LOW,
      REG_CH0_QUEUED_HIGH, REG_CH0_QUEUED_LOW, REG_CH1_QUEUED_HIGH,
      REG_CH1_QUEUED_LOW: w = res.value[ptr[2:0]];
      REG_LOW_LIMIT: w = set.low_limit;
      REG_HIGH_LIMIT: w = set.high_limit;
      REG_CONVERSION_SETUP: w = set.conversion_setup;
      REG_INTERRUPT_AND_BUS_SETUP: w = set.bus_setup;
      REG_EVENT_FLAGS: w = res.flags;
      REG_PART_IDENTITY: w = part;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // address from the strap code
  function automatic logic [6:0] own_addr(input logic [1:0] sel);
    return TARGET_ADDR_BASE | {5'h00, sel};
  endfunction

  // power-on defaults of the setup registers
  function automatic lsi_setup_type setup_defaults();
    lsi_setup_type s;
    s.low_limit = LOW_LIMIT_RESET;
    s.high_limit = HIGH_LIMIT_RESET;
    s.conversion_setup = CONVERSION_SETUP_RESET;
    s.bus_setup = BUS_SETUP_RESET;
    return s;
  endfunction

  logic scl_s, sda_s;
  logic [1:0] addr_s;
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_cond, stop_cond, timeout;
  lsi_state_type st_q, st_d;
  lsi_phase_type ph_q, ph_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] saved_q, saved_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [15:0] tx_word;
  logic ack_q, ack_d;
  logic rd_q, rd_d;
  logic rlo_q, rlo_d;
  logic drv_q, drv_d;
  logic hs_q, hs_d;
  logic [6:0] own_q, own_d;
  lsi_setup_type set_q, set_d;
  logic [19:0] to_q, to_d;

  // scl and sda share the mode-dependent filter
  lsi_sync #(.WIDTH(2)) u_bus_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .fast(hs_q),
    .din({SCL_IN, SDA_IN}),
    .dout({scl_s, sda_s})
  );

  // strap pin is static, but still crosses in through two flops
  lsi_sync #(.WIDTH(2)) u_addr_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .fast(1'b1),
    .din(ADDR_SEL),
    .dout(addr_s)
  );

  // bus events from filtered levels and their previous samples
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign timeout = (to_q == TIMEOUT_CYCLES[19:0] - 20'h00001);
  assign rx_byte = {sh_q[6:0], sda_s};
  assign tx_word = rd_word(ptr_q, RESULTS, set_q, PART_ID_VALUE);
  assign tx_byte = rlo_q ? tx_word[7:0] : tx_word[15:8];

  // scl low counter, only armed inside a transaction
  always_comb begin
    if (st_q == ST_IDLE || scl_s) begin
      to_d = 20'h00000;
    end else if (timeout) begin
      to_d = to_q;
    end else begin
      to_d = to_q + 20'h00001;
    end
  end

  // protocol engine
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    saved_d = saved_q;
    wbuf_d = wbuf_q;
    ack_d = ack_q;
    rd_d = rd_q;
    rlo_d = rlo_q;
    drv_d = drv_q;
    hs_d = hs_q;
    own_d = own_q;
    set_d = set_q;
    if (stop_cond) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
      hs_d = 1'b0;
      // saved equals ptr unless a burst advanced it
      ptr_d = saved_q;
    end else if (start_cond) begin
      st_d = ST_RX;
      ph_d = PH_ADDR;
      bit_d = 3'h0;
      drv_d = 1'b0;
      own_d = own_addr(addr_s);
    end else if (timeout) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_d = rx_byte;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = ST_ACK_PEND;
              ack_d = 1'b0;
              rd_d = 1'b0;
              case (ph_q)
                PH_ADDR: begin
                  if (rx_byte[7:1] == own_q) begin
                    ack_d = 1'b1;
                    rd_d = rx_byte[0];
                    rlo_d = 1'b0;
                    ph_d = PH_PTR;
                  end else if (rx_byte == GENERAL_CALL_ADDR) begin
                    ack_d = 1'b1;
                    ph_d = PH_GC;
                  end else if (rx_byte[7:3] == HIGH_SPEED_CODE_PREFIX) begin
                    hs_d = 1'b1;
                  end
                end
                PH_PTR: begin
                  ack_d = 1'b1;
                  ptr_d = rx_byte;
                  saved_d = rx_byte;
                  ph_d = PH_DATA_HI;
                end
                PH_DATA_HI: begin
                  ack_d = 1'b1;
                  wbuf_d = rx_byte;
                  ph_d = PH_DATA_LO;
                end
                PH_DATA_LO: begin
                  ack_d = 1'b1;
                  ph_d = PH_DATA_HI;
                  // other pointers are read-only and keep their value
                  case (ptr_q)
                    REG_LOW_LIMIT: set_d.low_limit = {wbuf_q, rx_byte};
                    REG_HIGH_LIMIT: set_d.high_limit = {wbuf_q, rx_byte};
                    REG_CONVERSION_SETUP: set_d.conversion_setup = {wbuf_q, rx_byte};
                    REG_INTERRUPT_AND_BUS_SETUP: set_d.bus_setup = {wbuf_q, rx_byte};
                    default: ;
                  endcase
                end
                PH_GC: begin
                  if (rx_byte == GENERAL_CALL_RESET) begin
                    ack_d = 1'b1;
                    set_d = setup_defaults();
                    ptr_d = PTR_RESET;
                    saved_d = PTR_RESET;
                  end
                end
                default: ;
              endcase
            end
          end
        end
        ST_ACK_PEND: begin
          // a nack leaves sda free and waits for the next start
          if (scl_fall) begin
            drv_d = ack_q;
            st_d = ack_q ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_d = 3'h0;
            if (rd_q) begin
              sh_d = tx_byte;
              drv_d = ~tx_byte[7];
              st_d = ST_TX;
            end else begin
              drv_d = 1'b0;
              st_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = ST_TX_LAST;
            end
          end else if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            drv_d = ~sh_q[6];
          end
        end
        ST_TX_LAST: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            st_d = ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_d = ST_IDLE;
            end else if (rlo_q) begin
              rlo_d = 1'b0;
              st_d = ST_ACK;
              if (set_q.bus_setup[BURST_ENABLE_BIT]) begin
                ptr_d = ptr_q + 8'h01;
              end
            end else begin
              rlo_d = 1'b1;
              st_d = ST_ACK;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= ST_IDLE;
      ph_q <= PH_ADDR;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= PTR_RESET;
      saved_q <= PTR_RESET;
      wbuf_q <= 8'h00;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      rlo_q <= 1'b0;
      drv_q <= 1'b0;
      hs_q <= 1'b0;
      own_q <= TARGET_ADDR_BASE;
      set_q <= {LOW_LIMIT_RESET, HIGH_LIMIT_RESET, CONVERSION_SETUP_RESET, BUS_SETUP_RESET};
      to_q <= 20'h00000;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      saved_q <= saved_d;
      wbuf_q <= wbuf_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      rlo_q <= rlo_d;
      drv_q <= drv_d;
      hs_q <= hs_d;
      own_q <= own_d;
      set_q <= set_d;
      to_q <= to_d;
    end
  end

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = drv_q;
  assign SETUP = set_q;
  assign HIGH_SPEED_MODE = hs_q;

endmodule // lsi_i2c_target

// ===== bench/lsi_i2c_target_assertions.sv
// pin-level checks for the i2c target, bound to its top module
`timescale 1ns/1ps
module lsi_i2c_target_chk import lsi_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // bus pins and outputs
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OE,
  input wire lsi_setup_type SETUP,
  input wire logic HIGH_SPEED_MODE
);
  logic [19:0] low_q, low_d;
  logic [3:0] stop_q, stop_d;
  logic [1:0] pin_q, pin_d;
  logic stop_ev;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // scl low time and cycles since a stop on the pins, both saturating
  always_comb begin
    pin_d = {SCL_IN, SDA_IN};
    stop_ev = SCL_IN && pin_q[1] && SDA_IN && !pin_q[0];
    low_d = SCL_IN ? 20'h0 : low_q + {19'h0, ~&low_q};
    stop_d = stop_ev ? 4'h0 : stop_q + {3'h0, ~&stop_q};
  end
  // idle bus assumed out of reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      low_q <= 20'h0;
      stop_q <= 4'hF;
      pin_q <= 2'h3;
    end else begin
      low_q <= low_d;
      stop_q <= stop_d;
      pin_q <= pin_d;
    end
  end
  sequence s_stop; stop_ev; endsequence
  sequence s_no_ack; !SDA_OE [*8]; endsequence
  property p_hs_exit; s_stop |-> ##[1:8] !HIGH_SPEED_MODE; endproperty
  a_hs_exit: assert property (p_hs_exit)
    else $error("high speed mode kept after stop");
  property p_hs_cause; $fell(HIGH_SPEED_MODE) |-> stop_q < 4'h8; endproperty
  a_hs_cause: assert property (p_hs_cause)
    else $error("high speed mode left without stop");
  property p_hs_no_ack; $rose(HIGH_SPEED_MODE) |-> s_no_ack; endproperty
  a_hs_no_ack: assert property (p_hs_no_ack)
    else $error("high speed code acknowledged");
  property p_oe_scl_low; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda changed while scl high");
  property p_oe_stands; $rose(SDA_OE) |-> SDA_OE [*7]; endproperty
  a_oe_stands: assert property (p_oe_stands)
    else $error("sda low released too soon");
  property p_setup_acked; $changed(SETUP) |-> ##[1:12] SDA_OE; endproperty
  a_setup_acked: assert property (p_setup_acked)
    else $error("setup changed without ack");
  property p_setup_quiet; SDA_OE && $past(SDA_OE) |-> $stable(SETUP); endproperty
  a_setup_quiet: assert property (p_setup_quiet)
    else $error("setup changed while target drives");
  property p_timeout; low_q > TIMEOUT_CYCLES + 16 |-> !SDA_OE; endproperty
  a_timeout: assert property (p_timeout)
    else $error("sda held after scl timeout");
endmodule // lsi_i2c_target_chk

bind lsi_i2c_target lsi_i2c_target_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE),
  .SETUP(SETUP), .HIGH_SPEED_MODE(HIGH_SPEED_MODE));

// ===== bench/lsi_ctl_model.sv
// behavioural i2c bus controller: drives scl, pulls sda low
`timescale 1ns/1ps
module lsi_ctl_model (
  // time base
  input wire logic clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  // each received byte, flagged for one clock
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // also stretches scl low when called mid-frame
  task hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start or repeated start, waits out a target still driving
  task start;
    hold(3);
    sda_low = 1'b0;
    hold(3);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask
  task stop;
    hold(3);
    sda_low = 1'b1;
    hold(3);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b0;
    hold(4);
  endtask
  // 6 clocks low, 2 high; long low gives the target time to turn sda
  task bitx(input logic v, output logic s);
    hold(3);
    sda_low = !v;
    hold(3);
    scl = 1'b1;
    hold(1);
    s = sda;
    hold(1);
    scl = 1'b0;
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  task rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(!ack, s);
    rx_byte = b;
    rx_stb = 1'b1;
    hold(1);
    rx_stb = 1'b0;
  endtask
endmodule // lsi_ctl_model

// ===== bench/tb_i2c_target_register_access.sv
// self-checking bench for the i2c target register access block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_i2c_target_register_access import lsi_pkg::*;;
  localparam int unsigned TO = 200;
  localparam logic [15:0] PID = 16'hC3A5; // arbitrary identity value
  logic clk, rst_n, scl, sda_low, sda_oe, sda_out, hs, rx_stb, bt;
  logic [1:0] sel;
  logic [6:0] adr;
  logic [7:0] rx_byte, ptr_m, ab, e;
  logic [31:0] seed = 32'hFE25;
  lsi_results_type res;
  lsi_setup_type setup, set_m;
  logic [7:0] q[$];
  int mismatches, n_tests;
  wire sda = !(sda_low | sda_oe); // pull-up unless someone pulls low
  lsi_i2c_target #(.TIMEOUT_CYCLES(TO), .PART_ID_VALUE(PID)) u_dut (
    .MCLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_SEL(sel), .RESULTS(res), .SETUP(setup),
    .HIGH_SPEED_MODE(hs));
  lsi_ctl_model u_ctl (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .rx_stb(rx_stb), .rx_byte(rx_byte));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // expected word at a pointer; unmapped places read zero
  function automatic logic [15:0] ev(input logic [7:0] p);
    case (p)
      8'h08: return set_m.low_limit;
      8'h09: return set_m.high_limit;
      8'h0A: return set_m.conversion_setup;
      8'h0B: return set_m.bus_setup;
      8'h0C: return res.flags;
      8'h11: return PID;
      default: return (p < 8'h08) ? res.value[p[2:0]] : 16'h0000;
    endcase
  endfunction
  // received bytes against the oldest expected byte
  always @(posedge clk) begin
    if (rx_stb) begin
      e = q.pop_front();
      `CHK(rx_byte, e)
    end
  end
  task sb(input logic [7:0] b, input logic ea);
    logic a;
    u_ctl.wbyte(b, a);
    `CHK(a, ea)
  endtask
  task wr(input logic [7:0] p, input logic [15:0] v, input logic full);
    u_ctl.start();
    sb({adr, 1'b0}, 1'b1);
    sb(p, 1'b1);
    ptr_m = p;
    if (full) begin
      sb(v[15:8], 1'b1);
      sb(v[7:0], 1'b1);
      if (p >= 8'h08 && p <= 8'h0B) set_m[16 * (8'h0B - p) +: 16] = v;
    end
    u_ctl.stop();
  endtask
  task rd(input int n);
    logic [7:0] p, b;
    logic [15:0] w;
    p = ptr_m;
    u_ctl.start();
    sb({adr, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      w = ev(p);
      q.push_back(w[15:8]);
      q.push_back(w[7:0]);
      u_ctl.rbyte(1'b1, b);
      u_ctl.rbyte(k < n - 1, b);
      if (set_m.bus_setup[BURST_ENABLE_BIT]) p++;
    end
    u_ctl.stop();
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    sel = 2'h0;
    adr = 7'h44;
    res = '0;
    set_m = {LOW_LIMIT_RESET, HIGH_LIMIT_RESET, CONVERSION_SETUP_RESET, BUS_SETUP_RESET};
    ptr_m = 8'h00;
    repeat (16) @(negedge clk);
    for (int i = 0; i < 8; i++) res.value[i] = 16'(lfsr());
    res.flags = 16'(lfsr());
    `CHK(setup, set_m)
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    // each strap answers its own address and refuses the one differing in bit 0
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      adr = 7'h44 + 7'(s);
      u_ctl.start();
      sb({adr ^ 7'h01, 1'b0}, 1'b0);
      u_ctl.stop();
      wr(8'h00, 16'h0000, 1'b0);
    end
    $display("address select done");
    // whole map from reset, each pointer read twice without rewrite
    for (int p = 0; p < 18; p++) begin
      wr(8'(p), 16'h0000, 1'b0);
      rd(1);
      rd(1);
    end
    $display("map read done");
    // random words everywhere; read-only places keep their contents
    for (int p = 0; p < 18; p++) begin
      wr(8'(p), 16'(lfsr()), 1'b1);
      rd(1);
      `CHK(setup, set_m)
    end
    $display("write done");
    wr(8'h0B, 16'h0001, 1'b1);
    wr(8'h00, 16'h0000, 1'b0);
    rd(8);
    rd(1);
    wr(8'h0B, 16'h0000, 1'b1);
    wr(8'h04, 16'h0000, 1'b0);
    rd(2);
    $display("burst done");
    u_ctl.start();
    sb({5'h01, 3'(lfsr())}, 1'b0);
    `CHK(hs, 1'b1)
    wr(8'h09, 16'hA55A, 1'b1);
    u_ctl.hold(8);
    `CHK(hs, 1'b0)
    `CHK(setup.high_limit, 16'hA55A)
    $display("high speed done");
    // general call with any other byte is refused and changes nothing
    u_ctl.start();
    sb(8'h00, 1'b1);
    sb(8'h04, 1'b0);
    `CHK(setup, set_m)
    u_ctl.start();
    sb(8'h00, 1'b1);
    sb(8'h06, 1'b1);
    u_ctl.stop();
    set_m = {LOW_LIMIT_RESET, HIGH_LIMIT_RESET, CONVERSION_SETUP_RESET, BUS_SETUP_RESET};
    ptr_m = 8'h00;
    `CHK(setup, set_m)
    rd(1);
    $display("general call done");
    // scl held low in the ack slot
    ab = {adr, 1'b0};
    u_ctl.start();
    for (int i = 7; i >= 0; i--) u_ctl.bitx(ab[i], bt);
    u_ctl.hold(8);
    `CHK(sda_oe, 1'b1)
    `CHK(sda_out, 1'b0)
    u_ctl.hold(TO + 40);
    `CHK(sda_oe, 1'b0)
    u_ctl.stop();
    rd(1);
    $display("timeout done");
    `CHK(q.size(), 0)
    conclude();
  end
endmodule // tb_i2c_target_register_access
